// ===== hdl/fps_cfg.svh
/*
 * constants of the flash programming status and security block:
 * register offsets, reset values, fuse positions and timing counts.
 * assumes a 40 MHz pclk and a 32-bit apb with byte addresses.
 */
`ifndef FPS_CFG_SVH
`define FPS_CFG_SVH

// ==========================================================
// register byte offsets
`define FPS_OFF_STATUS   8'h00
`define FPS_OFF_CMD      8'h04
`define FPS_OFF_POLL     8'h08
`define FPS_OFF_CONFIG   8'h0C
`define FPS_OFF_NVSTATE  8'h10

// ==========================================================
// nonvolatile defaults and byte values
`define FPS_FUSE_COUNT   11
`define FPS_FUSE_RESET   11'h7FF
`define FPS_LOCK_COUNT   2
`define FPS_LOCK_RESET   2'h3
`define FPS_BYTE_ONES    8'hFF
`define FPS_BYTE_ZERO    8'h00

// ==========================================================
// fuse row positions
`define FPS_FUSE_CS0     0
`define FPS_FUSE_CS1     1
`define FPS_FUSE_SUT0    2
`define FPS_FUSE_SUT1    3

// ==========================================================
// protection levels
`define FPS_LEVEL_1      2'h1
`define FPS_LEVEL_2      2'h2
`define FPS_LEVEL_3      2'h3

// ==========================================================
// timing
`define FPS_CLK_NS       25
`define FPS_PROG_TIME_NS 2000
`define FPS_PROG_CYCLES  ((`FPS_PROG_TIME_NS + `FPS_CLK_NS - 1) / `FPS_CLK_NS)
`define FPS_SUT0_CRYSTAL_OSCILLATOR_US 14'h03E8
`define FPS_SUT0_OTHR_US 14'h0010
`define FPS_SUT1_CRYSTAL_OSCILLATOR_US 14'h07D0
`define FPS_SUT1_OTHR_US 14'h0200
`define FPS_SUT2_CRYSTAL_OSCILLATOR_US 14'h0FA0
`define FPS_SUT2_OTHR_US 14'h03E8
`define FPS_SUT3_CRYSTAL_OSCILLATOR_US 14'h3E80
`define FPS_SUT3_OTHR_US 14'h0FA0

`endif

// ===== hdl/fps_pkg.sv
/*
 * types of the flash programming status and security block.
 * assumes fps_cfg.svh supplies the numeric constants.
 */
package fps_pkg;

  // ==========================================================
  // programming engine states, one-hot
  typedef enum logic [2:0] {
    st_idle  = 3'b001,
    st_prog  = 3'b010,
    st_erase = 3'b100
  } fps_state_e;

  // ==========================================================
  // command opcodes written to the command register
  typedef enum logic [3:0] {
    op_nop           = 4'h0,
    op_load          = 4'h1,
    op_write_page    = 4'h2,
    op_erase_page    = 4'h3,
    op_chip_erase    = 4'h4,
    op_fuse_write    = 4'h5,
    op_fuse_write_ae = 4'h6,
    op_lock_write    = 4'h7,
    op_app_write     = 4'h8
  } fps_op_e;

  // command word as carried in pwdata[19:0]
  typedef struct packed {
    fps_op_e    op;
    logic [7:0] addr;
    logic [7:0] data;
  } fps_cmd_s;

  // programming status byte
  typedef struct packed {
    logic [3:0] unused;
    logic       load;
    logic       success;
    logic       write_inhibit;
    logic       busy;
  } fps_status_s;

endpackage

// ===== hdl/fps_sync3.sv
/*
 * three-flop synchroniser with agreement filter.
 * assumes async_in is asynchronous to pclk.
 */
`timescale 1ns/1ps

module fps_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      level_out
);

  logic s1;         // metastable stage, read only by s2
  logic s2;
  logic s3;
  logic next_level;

  // ==========================================================
  // filter: a change counts once stages two and three agree
  always_comb begin
    next_level = level_out;
    if (s2 == s3) begin
      next_level = s2;
    end
  end

  // registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1        <= RESET_VAL;
      s2        <= RESET_VAL;
      s3        <= RESET_VAL;
      level_out <= RESET_VAL;
    end else begin
      s1        <= async_in;
      s2        <= s1;
      s3        <= s2;
      level_out <= next_level;
    end
  end

endmodule

// ===== hdl/fps_top.sv
/*
 * flash programming status, completion polling, lock security and
 * user fuse logic, reached over apb.
 * assumes brownout_detected is an asynchronous pin and app_write_req
 * comes from logic on pclk.
 */
`timescale 1ns/1ps
`include "fps_cfg.svh"

// Behaviour
// - status byte: load, success, inhibit, busy
// - load command clears load; write sets
// - success cleared at start, brownout keeps low
// - brownout drives write inhibit flag low
// - busy low while programming or inhibited
// - polling read inverts msb until the cycle ends
// - erase polls with all ones reference
// - poll reference is last byte loaded
// - lock bytes ones; only chip erase restores
// - protection level decoded from two locks
// - level two rejects all external programming but chip erase and lock writes
// - level three blocks reads and debug
// - application self writes ignore lock bits
// - eleven fuses, default all ones
// - zero clears fuse, ones keeps state
// - clock source from fuses one, zero
// - start-up delay codes zero zero, zero ones
// - start-up delay codes ones zero, ones ones
// - clock fuses take effect at power-on
module fps_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        brownout_detected,
  input  wire logic        app_write_req,
  input  wire logic [7:0]  app_write_data,
  output logic [1:0]       clock_source_sel,
  output logic [13:0]      startup_delay_us,
  output logic             on_chip_debug_en,
  output logic             ext_read_allowed
);

  localparam logic [7:0] PROG_LAST = 8'(`FPS_PROG_CYCLES - 1);

  // ==========================================================
  // state
  fps_pkg::fps_state_e               state;          // engine state
  fps_pkg::fps_state_e               next_state;
  logic [7:0]                        cnt;            // cycles left in cycle
  logic [7:0]                        next_cnt;
  fps_pkg::fps_cmd_s                 pend;           // operation in flight
  fps_pkg::fps_cmd_s                 next_pend;
  logic                              load_flag;
  logic                              next_load_flag;
  logic                              success_flag;
  logic                              next_success_flag;
  logic                              bod_hit;        // brownout seen in cycle
  logic                              next_bod_hit;
  logic [7:0]                        poll_ref;       // polling reference byte
  logic [7:0]                        next_poll_ref;
  logic [`FPS_FUSE_COUNT-1:0]        fuse_row;       // 1 = fuse reads ffh
  logic [`FPS_FUSE_COUNT-1:0]        next_fuse_row;
  logic [`FPS_LOCK_COUNT-1:0]        lock_bits;      // 1 = lock reads ffh
  logic [`FPS_LOCK_COUNT-1:0]        next_lock_bits;
  logic                              rejected;       // last command refused
  logic                              next_rejected;
  logic                              brownout_detector;            // synchronised brownout
  logic [1:0]                        level;          // protection level
  fps_pkg::fps_status_s              status;
  fps_pkg::fps_cmd_s                 cmd;
  logic                              cmd_wr;
  logic                              setup;
  logic                              prog_ok;

  // ==========================================================
  // brownout pin crossing
  fps_sync3 #(
    .RESET_VAL (1'b0)
  ) u_bod_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .async_in  (brownout_detected),
    .level_out (brownout_detector)
  );

  // ==========================================================
  // decode: protection level and status byte
  always_comb begin
    case (lock_bits)
      2'b11:   level = `FPS_LEVEL_1;
      2'b10:   level = `FPS_LEVEL_2;
      default: level = `FPS_LEVEL_3;
    endcase
    status               = '0;
    status.load          = load_flag;
    status.success       = success_flag;
    status.write_inhibit = ~brownout_detector;
    status.busy          = (state == fps_pkg::st_idle) & ~brownout_detector;
    // page writes, page erase and fuse writes only with no lock and a good supply
    prog_ok = (level == `FPS_LEVEL_1) & ~brownout_detector;
    cmd     = fps_pkg::fps_cmd_s'(pwdata[19:0]);
    setup   = psel & ~penable;
    cmd_wr  = psel & penable & pready & pwrite & (paddr == `FPS_OFF_CMD);
  end

  // ==========================================================
  // programming engine next state
  always_comb begin
    next_state        = state;
    next_cnt          = cnt;
    next_pend         = pend;
    next_load_flag    = load_flag;
    next_success_flag = success_flag;
    next_bod_hit      = bod_hit;
    next_poll_ref     = poll_ref;
    next_fuse_row     = fuse_row;
    next_lock_bits    = lock_bits;
    next_rejected     = rejected;
    case (state)
      fps_pkg::st_idle: begin
        if (app_write_req && !brownout_detector) begin
          // self writes bypass the lock levels entirely
          next_state        = fps_pkg::st_prog;
          next_cnt          = PROG_LAST;
          next_pend         = '{op: fps_pkg::op_app_write, addr: 8'h00, data: app_write_data};
          next_success_flag = 1'b0;
          next_bod_hit      = 1'b0;
          next_poll_ref     = app_write_data;
        end else if (cmd_wr) begin
          next_rejected = 1'b0;
          next_pend     = cmd;
          case (cmd.op)
            fps_pkg::op_load: begin
              next_load_flag = 1'b0;
              next_poll_ref  = cmd.data;
            end
            fps_pkg::op_write_page: begin
              if (prog_ok) begin
                next_state        = fps_pkg::st_prog;
                next_load_flag    = 1'b1;
                next_success_flag = 1'b0;
              end else begin
                next_rejected = 1'b1;
              end
            end
            fps_pkg::op_erase_page, fps_pkg::op_chip_erase: begin
              if (prog_ok || (cmd.op == fps_pkg::op_chip_erase && !brownout_detector)) begin
                next_state        = fps_pkg::st_erase;
                next_poll_ref     = `FPS_BYTE_ONES;
                next_success_flag = 1'b0;
              end else begin
                next_rejected = 1'b1;
              end
            end
            fps_pkg::op_fuse_write, fps_pkg::op_fuse_write_ae: begin
              if (prog_ok && cmd.addr < 8'(`FPS_FUSE_COUNT)) begin
                next_state        = fps_pkg::st_prog;
                next_poll_ref     = cmd.data;
                next_success_flag = 1'b0;
              end else begin
                next_rejected = 1'b1;
              end
            end
            fps_pkg::op_lock_write: begin
              if (!brownout_detector && cmd.addr < 8'(`FPS_LOCK_COUNT)) begin
                next_state        = fps_pkg::st_prog;
                next_poll_ref     = cmd.data;
                next_success_flag = 1'b0;
              end else begin
                next_rejected = 1'b1;
              end
            end
            default: begin
              next_rejected = 1'b1;
            end
          endcase
          next_cnt     = PROG_LAST;
          next_bod_hit = 1'b0;
        end
      end
      fps_pkg::st_prog, fps_pkg::st_erase: begin
        if (brownout_detector) begin
          next_bod_hit = 1'b1;
        end
        if (cnt == 8'h00) begin
          next_state        = fps_pkg::st_idle;
          next_success_flag = ~bod_hit & ~brownout_detector;
          if (!bod_hit && !brownout_detector) begin
            case (pend.op)
              fps_pkg::op_chip_erase: begin
                next_lock_bits = `FPS_LOCK_RESET;
              end
              fps_pkg::op_lock_write: begin
                if (pend.data == `FPS_BYTE_ZERO) begin
                  next_lock_bits[pend.addr[0]] = 1'b0;
                end
              end
              fps_pkg::op_fuse_write, fps_pkg::op_fuse_write_ae: begin
                // the auto-erase sweep sets the row to all ones on its first byte
                if (pend.op == fps_pkg::op_fuse_write_ae && pend.addr == 8'h00) begin
                  next_fuse_row = `FPS_FUSE_RESET;
                end
                if (pend.data == `FPS_BYTE_ZERO) begin
                  next_fuse_row[pend.addr[3:0]] = 1'b0;
                end
              end
              default: begin
              end
            endcase
          end
        end else begin
          next_cnt = cnt - 8'h01;
        end
        if (cmd_wr) begin
          next_rejected = 1'b1;                           // busy, refused
        end
      end
      default: begin
        next_state = fps_pkg::st_idle;
      end
    endcase
  end

  // engine registers; nonvolatile cells default to all ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= fps_pkg::st_idle;
      cnt          <= 8'h00;
      pend         <= '0;
      load_flag    <= 1'b0;
      success_flag <= 1'b0;
      bod_hit      <= 1'b0;
      poll_ref     <= `FPS_BYTE_ONES;
      fuse_row     <= `FPS_FUSE_RESET;
      lock_bits    <= `FPS_LOCK_RESET;
      rejected     <= 1'b0;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      pend         <= next_pend;
      load_flag    <= next_load_flag;
      success_flag <= next_success_flag;
      bod_hit      <= next_bod_hit;
      poll_ref     <= next_poll_ref;
      fuse_row     <= next_fuse_row;
      lock_bits    <= next_lock_bits;
      rejected     <= next_rejected;
    end
  end

  // ==========================================================
  // apb slave: answer one cycle after setup
  logic [31:0] next_prdata;
  logic        next_pslverr;
  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (setup) begin
      case (paddr)
        `FPS_OFF_STATUS:  next_prdata[7:0] = status;
        `FPS_OFF_POLL: begin
          // completion polling: msb inverted until the cycle ends
          if (state != fps_pkg::st_idle) begin
            next_prdata[7:0] = {~poll_ref[7], poll_ref[6:0]};
          end else begin
            next_prdata[7:0] = poll_ref;
          end
        end
        `FPS_OFF_CONFIG:  next_prdata[8:0] = {rejected, ext_read_allowed, on_chip_debug_en,
                                              startup_delay_us[13:12], clock_source_sel, level};
        `FPS_OFF_NVSTATE: next_prdata[12:0] = {lock_bits, fuse_row};
        `FPS_OFF_CMD:     next_prdata = 32'h0000_0000;
        default:          next_pslverr = 1'b1;
      endcase
      if (pwrite && paddr != `FPS_OFF_CMD) begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // power-on configuration: captured once after reset release
  logic        cfg_done;
  logic        next_cfg_done;
  logic [1:0]  next_clock_source_sel;
  logic [1:0]  sut_lat;
  logic [1:0]  next_sut_lat;
  logic [13:0] next_startup_delay_us;
  always_comb begin
    next_cfg_done         = 1'b1;
    next_clock_source_sel = clock_source_sel;
    next_sut_lat          = sut_lat;
    if (!cfg_done) begin
      // later fuse writes are ignored until the next power-on
      next_clock_source_sel = {fuse_row[`FPS_FUSE_CS1], fuse_row[`FPS_FUSE_CS0]};
      next_sut_lat          = {fuse_row[`FPS_FUSE_SUT1], fuse_row[`FPS_FUSE_SUT0]};
    end
    // crystal sources are the codes with the second fuse cleared
    case ({sut_lat, clock_source_sel[1]})
      3'b000:  next_startup_delay_us = `FPS_SUT0_CRYSTAL_OSCILLATOR_US;
      3'b001:  next_startup_delay_us = `FPS_SUT0_OTHR_US;
      3'b010:  next_startup_delay_us = `FPS_SUT1_CRYSTAL_OSCILLATOR_US;
      3'b011:  next_startup_delay_us = `FPS_SUT1_OTHR_US;
      3'b100:  next_startup_delay_us = `FPS_SUT2_CRYSTAL_OSCILLATOR_US;
      3'b101:  next_startup_delay_us = `FPS_SUT2_OTHR_US;
      3'b110:  next_startup_delay_us = `FPS_SUT3_CRYSTAL_OSCILLATOR_US;
      default: next_startup_delay_us = `FPS_SUT3_OTHR_US;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_done         <= 1'b0;
      clock_source_sel <= 2'h3;
      sut_lat          <= 2'h3;
      startup_delay_us <= `FPS_SUT3_OTHR_US;
      on_chip_debug_en <= 1'b0;
      ext_read_allowed <= 1'b0;
    end else begin
      cfg_done         <= next_cfg_done;
      clock_source_sel <= next_clock_source_sel;
      sut_lat          <= next_sut_lat;
      startup_delay_us <= next_startup_delay_us;
      on_chip_debug_en <= (level != `FPS_LEVEL_3);
      ext_read_allowed <= (level != `FPS_LEVEL_3);
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_status_upper;
    setup && paddr == `FPS_OFF_STATUS |=> prdata[7:4] == 4'h0 && prdata[0] == $past(status.busy);
  endproperty
  a_status_upper: assert property (p_status_upper) else $error("status upper bits not zero");

  property p_load_clear;
    cmd_wr && state == fps_pkg::st_idle && !app_write_req && cmd.op == fps_pkg::op_load |=> !load_flag;
  endproperty
  a_load_clear: assert property (p_load_clear) else $error("load flag not cleared");

  property p_success_start;
    state == fps_pkg::st_idle && next_state != fps_pkg::st_idle |=> !success_flag [*8];
  endproperty
  a_success_start: assert property (p_success_start) else $error("success high in cycle");

  property p_bod_fail;
    state != fps_pkg::st_idle && brownout_detector |=> !success_flag until_with (state == fps_pkg::st_idle);
  endproperty
  a_bod_fail: assert property (p_bod_fail) else $error("success after brownout");

  property p_write_inhibit_flag;
    brownout_detector |-> !status.write_inhibit && !status.busy;
  endproperty
  a_write_inhibit_flag: assert property (p_write_inhibit_flag) else $error("inhibit not shown");

  property p_busy;
    state != fps_pkg::st_idle |-> !status.busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy high while programming");

  property p_poll;
    setup && paddr == `FPS_OFF_POLL && state != fps_pkg::st_idle |=> prdata[7] != $past(poll_ref[7]);
  endproperty
  a_poll: assert property (p_poll) else $error("poll msb not inverted");

  property p_erase_ref;
    state == fps_pkg::st_idle && next_state == fps_pkg::st_erase |=> poll_ref == `FPS_BYTE_ONES;
  endproperty
  a_erase_ref: assert property (p_erase_ref) else $error("erase reference not ones");

  property p_level2;
    state == fps_pkg::st_idle && cmd_wr && !app_write_req && level != `FPS_LEVEL_1 &&
      cmd.op == fps_pkg::op_write_page |=>
      state == fps_pkg::st_idle && rejected;
  endproperty
  a_level2: assert property (p_level2) else $error("locked write accepted");

  property p_chip_unlock;
    state == fps_pkg::st_erase && cnt == 8'h00 && pend.op == fps_pkg::op_chip_erase && !brownout_detector && !bod_hit
      |=> lock_bits == `FPS_LOCK_RESET ##1 $stable(lock_bits);
  endproperty
  a_chip_unlock: assert property (p_chip_unlock) else $error("chip erase left locks");

  property p_app_bypass;
    state == fps_pkg::st_idle && app_write_req && !brownout_detector |=> state == fps_pkg::st_prog ##[1:200] state == fps_pkg::st_idle;
  endproperty
  a_app_bypass: assert property (p_app_bypass) else $error("self write blocked");

  property p_cfg_frozen;
    cfg_done |=> $stable(clock_source_sel) && $stable(sut_lat);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("clock fuses changed live");

  c_prog_ok:  cover property (state == fps_pkg::st_prog ##[1:200] success_flag);
  c_bod_hit:  cover property (state == fps_pkg::st_prog && brownout_detector ##[1:200] state == fps_pkg::st_idle);
  c_level3:   cover property (level == `FPS_LEVEL_3);
  c_poll_bsy: cover property (setup && paddr == `FPS_OFF_POLL && state == fps_pkg::st_erase);

endmodule

// ===== bench/fps_supply_model.sv
/*
 * supply side model: stands in for the brownout detector output pin.
 * assumes the bench raises dip to ask for a supply dip.
 */
`timescale 1ns/1ps

// ==========================================================
// supply model
module fps_supply_model (
  input  wire logic pclk,
  input  wire logic dip,
  output logic      brownout_detected
);
  // pin moves one edge after the request, like a slow comparator
  always_ff @(posedge pclk) begin
    brownout_detected <= dip;
  end
endmodule

// ===== bench/flash_program_status_and_security_tb_top.sv
/*
 * self-checking bench: apb master tasks, a table of register accesses,
 * then hand-written programming, brownout and lock cases.
 * assumes fps_top and fps_supply_model.
 */
`timescale 1ns/1ps

// ==========================================================
// bench top
module flash_program_status_and_security_tb_top;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] x; logic e;} fps_row_s;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, app_write_req = 0, dip = 0;
  logic [7:0]  paddr = 0, app_write_data = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, e, brownout_detected, on_chip_debug_en, ext_read_allowed;
  logic [1:0]  clock_source_sel;
  logic [13:0] startup_delay_us;
  int          fails = 0, compares = 0;
  fps_row_s    rows [6] = '{'{0, 8'h00, 32'h03, 0}, '{0, 8'h0C, 32'hCD, 0}, '{0, 8'h10, 32'h1FFF, 0},
                            '{0, 8'h04, 32'h0, 0}, '{0, 8'h14, 32'h0, 1}, '{1, 8'h00, 32'h0, 1}};

  always #12.5 pclk = ~pclk;

  fps_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .brownout_detected(brownout_detected), .app_write_req(app_write_req), .app_write_data(app_write_data),
    .clock_source_sel(clock_source_sel), .startup_delay_us(startup_delay_us),
    .on_chip_debug_en(on_chip_debug_en), .ext_read_allowed(ext_read_allowed));
  fps_supply_model i_sup (.pclk(pclk), .dip(dip), .brownout_detected(brownout_detected));

  // ==========================================================
  // closing report, reached from the end and from any timeout
  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // look at the settled answer mid-cycle; it is what the next rising edge samples
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    // the transfer completes at this edge; only then is the request released
    @(posedge pclk);
    psel <= 0; penable <= 0;
    if (n >= 20) begin
      fails++;
      report_and_stop;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = '1);
    apb(0, a, 0);
    chk("read", r & m, x);
  endtask

  task automatic cmd(input logic [3:0] op, input logic [7:0] a, input logic [7:0] d);
    apb(1, 8'h04, {12'h000, op, a, d});
  endtask

  // busy reads high only once idle and writable
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(0, 8'h00, 0);
      n++;
    end while (r[0] !== 1'b1 && n < 100);
    if (n >= 100) begin
      fails++;
      report_and_stop;
    end
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    chk("clock_source_sel", clock_source_sel, 3);
    chk("startup_delay_us", startup_delay_us, 14'h0FA0);
    chk("debug", {on_chip_debug_en, ext_read_allowed}, 3);
    $display("done reset");
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, 0);
      if (!rows[i].w) chk("row data", r, rows[i].x);
      chk("row err", e, rows[i].e);
    end
    $display("done table");
    cmd(1, 0, 8'h5A);
    cmd(1, 1, 8'hA5);
    cmd(2, 0, 8'h00);
    rd(8'h08, 32'h25);
    rd(8'h00, 32'h0A);
    wait_idle;
    rd(8'h00, 32'h0F);
    rd(8'h08, 32'hA5);
    cmd(1, 0, 8'h11);
    rd(8'h00, 32'h07);
    cmd(3, 0, 8'h00);
    rd(8'h08, 32'h7F);
    wait_idle;
    rd(8'h08, 32'hFF);
    $display("done polling");
    cmd(5, 0, 8'h00);
    wait_idle;
    cmd(5, 1, 8'hFF);
    wait_idle;
    rd(8'h10, 32'h1FFE);
    cmd(5, 11, 8'h00);
    rd(8'h0C, 32'h1CD);
    cmd(6, 0, 8'hFF);
    wait_idle;
    rd(8'h10, 32'h1FFF);
    $display("done fuses");
    dip <= 1;
    repeat (6) @(posedge pclk);
    rd(8'h00, 32'h0, 32'h3);
    cmd(2, 0, 8'h00);
    rd(8'h0C, 32'h100, 32'h100);
    dip <= 0;
    repeat (6) @(posedge pclk);
    cmd(2, 0, 8'h00);
    repeat (10) @(posedge pclk);
    dip <= 1;
    repeat (6) @(posedge pclk);
    dip <= 0;
    repeat (6) @(posedge pclk);
    wait_idle;
    rd(8'h00, 32'h0, 32'h4);
    $display("done brownout");
    cmd(7, 0, 8'h00);
    wait_idle;
    rd(8'h0C, 32'h2, 32'h3);
    cmd(5, 2, 8'h00);
    rd(8'h0C, 32'h100, 32'h100);
    app_write_data <= 8'h3C;
    app_write_req <= 1;
    @(posedge pclk);
    app_write_req <= 0;
    rd(8'h08, 32'hBC);
    wait_idle;
    cmd(7, 1, 8'h00);
    wait_idle;
    cmd(2, 0, 8'h00);
    rd(8'h0C, 32'h103, 32'h103);
    chk("debug", {on_chip_debug_en, ext_read_allowed}, 0);
    rd(8'h10, 32'h0, 32'h1800);
    cmd(4, 0, 8'h00);
    wait_idle;
    rd(8'h10, 32'h1800, 32'h1800);
    rd(8'h0C, 32'h1, 32'h3);
    $display("done locks");
    report_and_stop;
  end
endmodule
